// file: src/tcs_timer_clock_select.sv
// Timer clock-select register and per-timer tick generation.
// Assumes timer control bits come from logic on clk; extClk is a pin.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
module tcs_timer_clock_select (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic extClk,
    input wire logic timer3Split,
    input wire logic timer3ExtClkSel,
    input wire logic timer2Split,
    input wire logic timer2ExtClkSel,
    output logic timer3LowTick,
    output logic timer3HighTick,
    output logic timer2LowTick,
    output logic timer2HighTick,
    output logic [7:0] timerClockSelect
);
    tcs_pkg::tcs_bus_t busState_ff;
    logic [7:0] clkSel_ff;
    logic [31:0] readData_ff;
    logic [3:0] div12Count_ff;
    logic div12Tick_ff;
    logic extSync;
    logic extPrev_ff;
    logic [2:0] extCount_ff;
    logic extDiv8Tick_ff;
    logic t3LowTick_ff;
    logic t3HighTick_ff;
    logic t2LowTick_ff;
    logic t2HighTick_ff;
    logic t3ExtTick;
    logic t2ExtTick;
    logic nxt_t3Low;
    logic nxt_t3High;

    // One wait cycle, answer on the next
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busState_ff <= tcs_pkg::BUS_IDLE;
        end else begin
            case (busState_ff)
                tcs_pkg::BUS_IDLE: begin
                    if (read || write) begin
                        busState_ff <= tcs_pkg::BUS_ACK;
                    end
                end
                tcs_pkg::BUS_ACK: busState_ff <= tcs_pkg::BUS_IDLE;
                default: busState_ff <= tcs_pkg::BUS_IDLE;
            endcase
        end
    end

    assign waitrequest = (read || write) && (busState_ff != tcs_pkg::BUS_ACK);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clkSel_ff <= tcs_pkg::CLK_SEL_RESET;
        end else if (write && busState_ff == tcs_pkg::BUS_ACK
                     && address == tcs_pkg::ADDR_CLK_SEL) begin
            clkSel_ff <= writedata[7:0];
        end
    end

    // Read data; status word shows tick sources
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_ff <= 32'h0000_0000;
        end else if (read && busState_ff == tcs_pkg::BUS_IDLE) begin
            case (address)
                tcs_pkg::ADDR_CLK_SEL: readData_ff <= {24'h00_0000, clkSel_ff};
                tcs_pkg::ADDR_STATUS: readData_ff <= {28'h000_0000, timer3Split,
                    timer2Split, timer3ExtClkSel, timer2ExtClkSel};
                default: readData_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign readdata = readData_ff;
    assign timerClockSelect = clkSel_ff;

    // System clock divided by 12
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div12Count_ff <= 4'h0;
            div12Tick_ff <= 1'b0;
        end else begin
            div12Tick_ff <= (div12Count_ff == tcs_pkg::DIV12_LAST);
            div12Count_ff <= (div12Count_ff == tcs_pkg::DIV12_LAST) ? 4'h0
                : div12Count_ff + 4'h1;
        end
    end

    tcs_sync u_extSync (
        .clk(clk),
        .reset_n(reset_n),
        .asyncIn(extClk),
        .syncOut(extSync)
    ); // [R07]

    // External clock divided by 8 on synchronised rising edges
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            extPrev_ff <= 1'b0;
            extCount_ff <= 3'h0;
            extDiv8Tick_ff <= 1'b0;
        end else begin
            extPrev_ff <= extSync;
            extDiv8Tick_ff <= 1'b0;
            if (extSync && !extPrev_ff) begin // [R07]
                extCount_ff <= extCount_ff + 3'h1;
                extDiv8Tick_ff <= (extCount_ff == tcs_pkg::EXT_DIV_LAST);
            end
        end
    end

    assign t3ExtTick = timer3ExtClkSel ? extDiv8Tick_ff : div12Tick_ff; // [R03] [R04]
    assign t2ExtTick = timer2ExtClkSel ? extDiv8Tick_ff : div12Tick_ff; // [R06]

    always_comb begin
        nxt_t3Low = clkSel_ff[tcs_pkg::BIT_T3L] ? 1'b1 : t3ExtTick; // [R03] [R08]
        if (timer3Split) begin
            nxt_t3High = clkSel_ff[tcs_pkg::BIT_T3H] ? 1'b1 : t3ExtTick; // [R02] [R04]
        end else begin
            nxt_t3High = nxt_t3Low; // [R01] [R05]
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            t3LowTick_ff <= 1'b0;
            t3HighTick_ff <= 1'b0;
        end else begin
            t3LowTick_ff <= nxt_t3Low;
            t3HighTick_ff <= nxt_t3High;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            t2LowTick_ff <= 1'b0;
            t2HighTick_ff <= 1'b0;
        end else begin
            t2LowTick_ff <= clkSel_ff[tcs_pkg::BIT_T2L] ? 1'b1 : t2ExtTick; // [R06]
            if (timer2Split) begin
                t2HighTick_ff <= clkSel_ff[tcs_pkg::BIT_T2H] ? 1'b1 : t2ExtTick; // [R06]
            end else begin
                t2HighTick_ff <= clkSel_ff[tcs_pkg::BIT_T2L] ? 1'b1 : t2ExtTick;
            end
        end
    end

    assign timer3LowTick = t3LowTick_ff;
    assign timer3HighTick = t3HighTick_ff;
    assign timer2LowTick = t2LowTick_ff;
    assign timer2HighTick = t2HighTick_ff;
endmodule : tcs_timer_clock_select

// file: src/tcs_pkg.sv
// Constants for the timer clock-select block.
// Assumes a 200 MHz system clock and an Avalon-MM slave with waitrequest.
// Notes on behaviour
// [R01] Timer 3 16-bit mode clocks from low select
// [R02] Split mode: low select drives low byte only
// [R03] Low select 0 uses Timer 3 external choice
// [R04] High select 0 uses Timer 3 external choice
// [R05] High select ignored outside split mode
// [R06] Timer 2 selects: system clock or external choice
// [R07] External clock synchronised before it is divided
// [R08] Select 1 clocks byte from system clock
package tcs_pkg;
    localparam logic [1:0] ADDR_CLK_SEL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [7:0] CLK_SEL_RESET = 8'h00;
    localparam int BIT_T3H = 7;
    localparam int BIT_T3L = 6;
    localparam int BIT_T2H = 5;
    localparam int BIT_T2L = 4;
    localparam int BIT_T1 = 3;
    localparam int BIT_T0 = 2;
    localparam int BIT_SCA_HI = 1;
    localparam int BIT_SCA_LO = 0;
    localparam logic [3:0] DIV12_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } tcs_bus_t;
endpackage : tcs_pkg

// file: src/tcs_sync.sv
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to clk.
module tcs_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic asyncIn,
    output logic syncOut
);
    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule : tcs_sync

// file: sim/tcs_props.sv
// Port checker for the timer clock-select block.
// Assumes one clock domain; bound to tcs_timer_clock_select below.
module tcs_props (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic waitrequest,
    input wire logic timer3Split,
    input wire logic timer2Split,
    input wire logic timer3LowTick,
    input wire logic timer3HighTick,
    input wire logic timer2LowTick,
    input wire logic timer2HighTick,
    input wire logic [7:0] timerClockSelect
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    sel_write_a: assert property (write && !waitrequest && address == 2'h0
        |=> timerClockSelect == $past(writedata[7:0])) else $error("select not stored");
    t3_low_sys_a: assert property ($past(timerClockSelect[6] && reset_n) |-> timer3LowTick)
        else $error("timer 3 low not on system clock");
    t3_joined_a: assert property (!$past(timer3Split) |-> timer3HighTick == timer3LowTick)
        else $error("timer 3 halves differ in 16-bit mode");
    t3_high_sys_a: assert property ($past(timer3Split && timerClockSelect[7] && reset_n)
        |-> timer3HighTick) else $error("timer 3 high not on system clock");
    t2_low_sys_a: assert property ($past(timerClockSelect[4] && reset_n) |-> timer2LowTick)
        else $error("timer 2 low not on system clock");
    t2_high_sys_a: assert property ($past(timer2Split && timerClockSelect[5] && reset_n)
        |-> timer2HighTick) else $error("timer 2 high not on system clock");
    t3_pulse_a: assert property (!timerClockSelect[6] && !$past(timerClockSelect[6])
        && timer3LowTick |=> !timer3LowTick) else $error("slow tick too long");
    cover property (write && !waitrequest);
    cover property (timer3Split && timerClockSelect[7]);
    cover property (timer2LowTick && !timerClockSelect[4]);
endmodule : tcs_props

bind tcs_timer_clock_select tcs_props i_props (.*);

// file: sim/tcs_timer_clock_select_bench.sv
// Self-checking bench for the timer clock-select block.
// Assumes the checker is bound in by its own file.
module tcs_timer_clock_select_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset_n, read, write, extClk, waitrequest;
    logic timer3Split, timer3ExtClkSel, timer2Split, timer2ExtClkSel;
    logic timer3LowTick, timer3HighTick, timer2LowTick, timer2HighTick;
    logic [1:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [7:0] timerClockSelect, r;
    logic [2:0] cyc = 3'h0;
    int mismatches, checks_done, cnt;
    tcs_timer_clock_select i_dut (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 3'h1;
        extClk <= cyc[2];
    end
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    function automatic logic fast(input logic split, hi, lo);
        return split ? hi : lo;
    endfunction : fast
    task automatic chk(input string nm, input logic [31:0] e, s);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            mismatches++;
            $display("MISMATCH waitrequest expected 0 seen %b", waitrequest);
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        conclude();
    end
    initial begin
        {reset_n, read, write, address, writedata} = '0;
        {timer3Split, timer3ExtClkSel, timer2Split, timer2ExtClkSel} = '0;
        r = 8'h49;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        acc(1'b1, 2'h1, 32'hff);
        acc(1'b0, 2'h0, 32'h0);
        chk("reset", 32'h0, rd);
        acc(1'b0, 2'h2, 32'h0);
        chk("unmapped", 32'h0, rd);
        cnt = 0;
        repeat (120) begin
            @(negedge clk);
            cnt += int'(timer3LowTick);
        end
        chk("div12", 32'd10, cnt);
        for (int i = 0; i < 24; i++) begin
            r = lfsr(r);
            {timer2ExtClkSel, timer3ExtClkSel, timer2Split, timer3Split} <= r[3:0];
            acc(1'b1, 2'h0, {4{r}});
            acc(1'b0, 2'h0, 32'h0);
            chk("readback", {24'h0, r}, rd);
            chk("port", {24'h0, r}, {24'h0, timerClockSelect});
            acc(1'b0, 2'h1, 32'h0);
            chk("status", {28'h0, r[0], r[1], r[2], r[3]}, rd);
            if (r[6]) chk("t3low", 1, timer3LowTick);
            if (fast(r[0], r[7], r[6])) chk("t3high", 1, timer3HighTick);
            if (r[4]) chk("t2low", 1, timer2LowTick);
            if (fast(r[1], r[5], r[4])) chk("t2high", 1, timer2HighTick);
        end
        {timer2ExtClkSel, timer3ExtClkSel, timer2Split, timer3Split} <= 4'h4;
        acc(1'b1, 2'h0, 32'h0);
        repeat (8) @(posedge clk);
        cnt = 0;
        repeat (128) begin
            @(negedge clk);
            cnt += int'(timer3LowTick);
        end
        chk("ext8", 32'd2, cnt);
        conclude();
    end
endmodule : tcs_timer_clock_select_bench
